/* rtl/gsp_pkg.sv */
// Shared constants of the phase-selectable serial shifter: map, fields, timing.
// Assumes a 10 MHz register clock and a separate link clock for the shifter.
package gsp_pkg;
	localparam int LINK_PERIOD_PS = 48000;    // Link clock period
	localparam int SCK_PER_MIN_PS = 20800;    // Fastest shift clock period
	localparam int SCK_PER_MAX_PS = 62500000; // Slowest shift clock period
	localparam int SYNC_LAG_CYC   = 3;        // Half period must outrun input sync
	localparam int HALF_FAST_CYC  = (SCK_PER_MIN_PS + 2 * LINK_PERIOD_PS - 1)
		/ (2 * LINK_PERIOD_PS);
	localparam int HALF_MIN_CYC   = (HALF_FAST_CYC > SYNC_LAG_CYC) ? HALF_FAST_CYC
		: SYNC_LAG_CYC;
	localparam int HALF_MAX_CYC   = SCK_PER_MAX_PS / (2 * LINK_PERIOD_PS);
	localparam int XFER_BITS      = 8;
	localparam int XFER_EDGES     = 2 * XFER_BITS;
	localparam int ADDR_W         = 8;
	localparam logic [ADDR_W-1:0] OFF_CTRL   = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_CLKGEN = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_TXDATA = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_RXDATA = 8'h0c;
	localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h10;
	localparam int CTRL_LSB  = 0; // lsb_first_select
	localparam int CTRL_TXPH = 1; // transmit_clock_phase
	localparam int CTRL_RXPH = 2; // receive_clock_phase
	localparam int CTRL_HALF = 3; // Half duplex on line zero
	localparam int CTRL_HDTX = 4; // Half duplex direction, 1 = transmit
	localparam int CTRL_CS   = 5; // Chip select asserted
	localparam int CTRL_W    = 5;
	localparam int ST_BUSY   = 0;
	localparam int ST_RXFULL = 1;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic {GSP_IDLE, GSP_RUN} gsp_eng_state_t;
endpackage

/* rtl/gsp_link_if.sv */
// Carrier between register side and shift engine.
// Assumes words are held stable by the control side while a transfer runs.
`timescale 1ns/1ps
`default_nettype none
interface gsp_link_if #(parameter int DIV_W = 10);
	logic             start_tgl;
	logic             done_tgl;
	logic [7:0]       tx_byte;
	logic [7:0]       rx_byte;
	logic             lsb_first;
	logic             tx_phase;
	logic             rx_phase;
	logic             half_duplex;
	logic             hd_transmit;
	logic [DIV_W-1:0] half_div;
	modport ctl (output start_tgl, tx_byte, lsb_first, tx_phase, rx_phase, half_duplex,
		hd_transmit, half_div, input done_tgl, rx_byte);
	modport eng (input start_tgl, tx_byte, lsb_first, tx_phase, rx_phase, half_duplex,
		hd_transmit, half_div, output done_tgl, rx_byte);
endinterface // gsp_link_if
`default_nettype wire

/* rtl/gsp_sync.sv */
// Two-flop level synchroniser of parameter width.
// Assumes each bit is an independent level or a toggle.
`timescale 1ns/1ps
`default_nettype none
module gsp_sync #(parameter int W = 1) (
	input  wire logic         clk,
	input  wire logic         reset_n,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] stable;
	} gsp_sync_st_t;
	gsp_sync_st_t s_q;
	gsp_sync_st_t s_d;

	// First stage feeds only the second
	always_comb begin
		s_d.meta   = d;
		s_d.stable = s_q.meta;
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) s_q <= '0;
		else s_q <= s_d;
	end

	assign q = s_q.stable;
endmodule // gsp_sync
`default_nettype wire

/* rtl/gsp_shifter.sv */
// Shift engine on the link clock: clock divider, launch and sample by phase.
// Assumes control words stay stable from start toggle until done toggle.
`timescale 1ns/1ps
`default_nettype none
module gsp_shifter import gsp_pkg::*; #(parameter int DIV_W = 10) (
	input  wire logic       link_clk,
	input  wire logic       reset_n,
	gsp_link_if.eng         lk,
	input  wire logic [1:0] io_in,
	output logic            sck,
	output logic [3:0]      io_out,
	output logic [3:0]      io_oe_n
);
	typedef struct packed {
		gsp_eng_state_t   state;
		logic [DIV_W-1:0] half_cnt;
		logic [4:0]       edge_cnt;
		logic [3:0]       tx_idx;
		logic [3:0]       rx_idx;
		logic             sck;
		logic [3:0]       io_out;
		logic [3:0]       io_oe_n;
		logic [7:0]       rx_sr;
		logic             start_seen;
		logic             done_tgl;
	} gsp_eng_st_t;
	localparam gsp_eng_st_t ENG_RST = '{state: GSP_IDLE, io_oe_n: '1, default: '0};
	localparam logic [DIV_W-1:0] DIV_LO = DIV_W'(HALF_MIN_CYC);
	localparam logic [DIV_W-1:0] DIV_HI = DIV_W'(HALF_MAX_CYC);
	localparam logic [3:0] IDX_END = 4'(XFER_BITS);
	localparam logic [4:0] EDGE_END = 5'(XFER_EDGES);
	localparam logic [2:0] MSB_POS = 3'(XFER_BITS - 1);

	gsp_eng_st_t      s_q;
	gsp_eng_st_t      s_d;
	logic             start_s;
	logic [1:0]       io_s;
	logic [DIV_W-1:0] div_eff;
	logic             start_ev;
	logic             tick;
	logic [4:0]       e;
	logic             din;

	// Bit position of the n-th bit on the wire
	function automatic logic [2:0] bit_pos(input logic [3:0] idx, input logic lsb);
		bit_pos = lsb ? idx[2:0] : MSB_POS - idx[2:0];
	endfunction

	gsp_sync #(.W(1)) u_start_sync (.clk(link_clk), .reset_n(reset_n),
		.d(lk.start_tgl), .q(start_s));
	// Pins are asynchronous, hence the lower bound on the half period
	gsp_sync #(.W(2)) u_io_sync (.clk(link_clk), .reset_n(reset_n), .d(io_in), .q(io_s));

	// Divider clamp keeps the period inside the selectable range
	always_comb begin
		div_eff = lk.half_div;
		if (lk.half_div < DIV_LO) div_eff = DIV_LO;
		if (lk.half_div > DIV_HI) div_eff = DIV_HI;
	end

	// Engine next state
	always_comb begin
		s_d = s_q;
		start_ev = start_s != s_q.start_seen;
		tick = s_q.half_cnt == div_eff - 1'h1;
		e = s_q.edge_cnt + 5'h1;
		din = lk.half_duplex ? io_s[0] : io_s[1];
		unique case (s_q.state)
			GSP_IDLE: begin
				s_d.sck = 1'h0;
				s_d.io_oe_n[0] = lk.half_duplex && !lk.hd_transmit;
				if (start_ev) begin
					s_d.start_seen = start_s;
					s_d.state = GSP_RUN;
					s_d.half_cnt = '0;
					s_d.edge_cnt = '0;
					s_d.tx_idx = '0;
					s_d.rx_idx = '0;
					if (!lk.tx_phase) begin
						s_d.io_out[0] = lk.tx_byte[bit_pos(4'h0, lk.lsb_first)];
						s_d.tx_idx = 4'h1;
					end
				end
			end
			GSP_RUN: begin
				s_d.half_cnt = tick ? '0 : s_q.half_cnt + 1'h1;
				if (tick) begin
					s_d.sck = !s_q.sck;
					s_d.edge_cnt = e;
					// Odd edges launch for phase one, even ones for phase zero
					if ((lk.tx_phase ? e[0] : !e[0]) && s_q.tx_idx < IDX_END) begin
						s_d.io_out[0] = lk.tx_byte[bit_pos(s_q.tx_idx, lk.lsb_first)];
						s_d.tx_idx = s_q.tx_idx + 4'h1;
					end
					if ((lk.rx_phase ? !e[0] : e[0]) && s_q.rx_idx < IDX_END) begin
						s_d.rx_sr[bit_pos(s_q.rx_idx, lk.lsb_first)] = din;
						s_d.rx_idx = s_q.rx_idx + 4'h1;
					end
					if (e == EDGE_END) begin
						s_d.state = GSP_IDLE;
						s_d.done_tgl = !s_q.done_tgl;
					end
				end
			end
		endcase
	end

	always_ff @(posedge link_clk or negedge reset_n) begin
		if (!reset_n) s_q <= ENG_RST;
		else s_q <= s_d;
	end

	assign sck = s_q.sck;
	assign io_out = s_q.io_out;
	assign io_oe_n = s_q.io_oe_n;
	assign lk.rx_byte = s_q.rx_sr;
	assign lk.done_tgl = s_q.done_tgl;

	default clocking cb @(posedge link_clk); endclocking
	default disable iff (!reset_n);
	property p_first_tph0;
		(s_q.state == GSP_IDLE && start_ev && !lk.tx_phase)
			|=> s_q.io_out[0] == lk.tx_byte[bit_pos(4'h0, lk.lsb_first)];
	endproperty
	a_first_tph0: assert property (p_first_tph0) else $error("first bit not at select");
	property p_tph_hold;
		(s_q.state == GSP_IDLE && start_ev && lk.tx_phase) |=> $stable(s_q.io_out[0]);
	endproperty
	a_tph_hold: assert property (p_tph_hold) else $error("phase one launched early");
	property p_launch_edge;
		(s_q.state == GSP_RUN && s_d.tx_idx != s_q.tx_idx)
			|-> s_d.sck != s_q.sck && s_d.sck == lk.tx_phase;
	endproperty
	a_launch_edge: assert property (p_launch_edge) else $error("launch on wrong edge");
	property p_lsb_order;
		(s_q.state == GSP_RUN && s_d.tx_idx != s_q.tx_idx)
			|=> s_q.io_out[0] == lk.tx_byte[bit_pos($past(s_q.tx_idx), lk.lsb_first)];
	endproperty
	a_lsb_order: assert property (p_lsb_order) else $error("bit order wrong");
	property p_sample_edge;
		(s_q.state == GSP_RUN && s_d.rx_idx != s_q.rx_idx)
			|-> s_d.sck != s_q.sck && s_d.sck == !lk.rx_phase;
	endproperty
	a_sample_edge: assert property (p_sample_edge) else $error("sample on wrong edge");
	property p_duty;
		$changed(s_q.sck) |=> $stable(s_q.sck) [*2];
	endproperty
	a_duty: assert property (p_duty) else $error("shift clock half period too short");
	property p_eight;
		(s_q.state == GSP_RUN && tick && s_q.edge_cnt == EDGE_END - 5'h1)
			|=> s_q.state == GSP_IDLE && !s_q.sck && $changed(s_q.done_tgl);
	endproperty
	a_eight: assert property (p_eight) else $error("transfer did not end idle");
	property p_hd_oe;
		(s_q.state == GSP_IDLE && lk.half_duplex && !lk.hd_transmit) |=> s_q.io_oe_n[0];
	endproperty
	a_hd_oe: assert property (p_hd_oe) else $error("line zero driven while receiving");
	property p_div_range;
		div_eff >= DIV_LO && div_eff <= DIV_HI;
	endproperty
	a_div_range: assert property (p_div_range) else $error("divider out of range");
	c_both_one: cover property (s_q.state == GSP_RUN && lk.tx_phase && lk.rx_phase
		##1 s_q.state == GSP_IDLE);
	c_hd_rx: cover property (s_q.state == GSP_RUN && lk.half_duplex && !lk.hd_transmit
		##1 s_q.state == GSP_IDLE);
endmodule // gsp_shifter
`default_nettype wire

/* rtl/gsp_top.sv */
// Serial shifter top: AXI4-Lite register slave, chip select, link crossing.
// Assumes clk is the register clock and link_clk the free-running shift base.
//
// Operation
// - Clear sends MSB first, set LSB first.
// - Phases 0/0: data at select, odd sampling.
// - Tx phase 1: master launches after first edge.
// - Rx phase 1: master samples on even edges.
// - Phases 1/1: both launch late, even sampling.
// - Chip select is a plain software bit.
// - Half duplex keeps the same phase timing.
// - Full duplex: line zero out, line one in.
// - Period set by divider, clamped to range.
// - High and low time equal halves.
`timescale 1ns/1ps
`default_nettype none
module gsp_top import gsp_pkg::*; #(
	parameter int DIV_W = 10
) (
	input  wire logic              clk,
	input  wire logic              reset_n,
	input  wire logic              link_clk,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	output logic [1:0]             s_axi_bresp,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   serial_shift_clock,
	output logic [3:0]             serial_io_out,
	output logic [3:0]             serial_io_oe_n,
	input  wire logic [1:0]        serial_io_in,
	output logic                   chip_select_n
);
	typedef struct packed {
		logic              aw_have;
		logic [ADDR_W-1:0] aw_addr;
		logic              w_have;
		logic [31:0]       w_data;
		logic [3:0]        w_strb;
		logic              awready;
		logic              wready;
		logic              bvalid;
		logic [1:0]        bresp;
		logic              arready;
		logic              rvalid;
		logic [31:0]       rdata;
		logic [1:0]        rresp;
		logic [CTRL_W-1:0] ctrl;
		logic [DIV_W-1:0]  div;
		logic [7:0]        tx;
		logic              busy;
		logic              start_tgl;
		logic              done_seen;
		logic              rx_full;
		logic              cs_n;
	} gsp_reg_st_t;
	localparam gsp_reg_st_t REG_RST = '{
		awready: 1'h1,
		wready:  1'h1,
		arready: 1'h1,
		div:     DIV_W'(HALF_MIN_CYC),
		cs_n:    1'h1,
		default: '0
	};

	gsp_reg_st_t s_q;
	gsp_reg_st_t s_d;
	logic        done_s;
	logic        done_ev;
	logic        wr_fire;
	logic        wr_ctrl;
	logic        wr_tx;

	gsp_link_if #(.DIV_W(DIV_W)) link ();

	// Word decode shared by read and write paths
	function automatic logic reg_hit(input logic [ADDR_W-1:0] a,
		input logic [ADDR_W-1:0] off);
		reg_hit = {a[ADDR_W-1:2], 2'h0} == off;
	endfunction

	// Any known register, the rest answer with an error
	function automatic logic reg_known(input logic [ADDR_W-1:0] a);
		reg_known = reg_hit(a, OFF_CTRL) || reg_hit(a, OFF_CLKGEN)
			|| reg_hit(a, OFF_TXDATA) || reg_hit(a, OFF_RXDATA)
			|| reg_hit(a, OFF_STATUS);
	endfunction

	// Done toggle comes from the link clock, so it is synchronised as a level
	gsp_sync #(.W(1)) u_done_sync (
		.clk(clk),
		.reset_n(reset_n),
		.d(link.done_tgl),
		.q(done_s)
	);

	gsp_shifter #(.DIV_W(DIV_W)) u_shifter (
		.link_clk(link_clk),
		.reset_n(reset_n),
		.lk(link),
		.io_in(serial_io_in),
		.sck(serial_shift_clock),
		.io_out(serial_io_out),
		.io_oe_n(serial_io_oe_n)
	);

	// Words towards the engine; all come from flops and stay put while busy
	assign link.start_tgl = s_q.start_tgl;
	assign link.tx_byte = s_q.tx;
	assign link.lsb_first = s_q.ctrl[CTRL_LSB];
	assign link.tx_phase = s_q.ctrl[CTRL_TXPH];
	assign link.rx_phase = s_q.ctrl[CTRL_RXPH];
	assign link.half_duplex = s_q.ctrl[CTRL_HALF];
	assign link.hd_transmit = s_q.ctrl[CTRL_HDTX];
	assign link.half_div = s_q.div;

	// Write strobe and target decode
	assign done_ev = done_s != s_q.done_seen;
	assign wr_fire = s_q.aw_have && s_q.w_have && !s_q.bvalid;
	assign wr_ctrl = wr_fire && reg_hit(s_q.aw_addr, OFF_CTRL);
	assign wr_tx = wr_fire && reg_hit(s_q.aw_addr, OFF_TXDATA);

	// Register slave and transfer control
	always_comb begin
		s_d = s_q;

		// Address and data are taken in either order
		if (s_axi_awvalid && s_q.awready) begin
			s_d.aw_have = 1'h1;
			s_d.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_q.wready) begin
			s_d.w_have = 1'h1;
			s_d.w_data = s_axi_wdata;
			s_d.w_strb = s_axi_wstrb;
		end
		if (s_q.bvalid && s_axi_bready) s_d.bvalid = 1'h0;

		// Write takes effect once both halves are held
		if (wr_fire) begin
			s_d.aw_have = 1'h0;
			s_d.w_have = 1'h0;
			s_d.bvalid = 1'h1;
			s_d.bresp = reg_known(s_q.aw_addr) ? RESP_OKAY : RESP_SLVERR;
			// Select may move at any time; mode bits only between bytes
			if (wr_ctrl && s_q.w_strb[0]) begin
				s_d.cs_n = !s_q.w_data[CTRL_CS];
				if (!s_q.busy) s_d.ctrl = s_q.w_data[CTRL_W-1:0];
			end
			if (reg_hit(s_q.aw_addr, OFF_CLKGEN) && !s_q.busy
				&& s_q.w_strb[1:0] == 2'h3) begin
				s_d.div = s_q.w_data[DIV_W-1:0];
			end
			// A byte written while busy is dropped, status tells software
			if (wr_tx && !s_q.busy && s_q.w_strb[0]) begin
				s_d.tx = s_q.w_data[7:0];
				s_d.busy = 1'h1;
				s_d.start_tgl = !s_q.start_tgl;
			end
		end

		// Read answer, one cycle after the address is taken
		if (s_q.rvalid && s_axi_rready) s_d.rvalid = 1'h0;
		if (s_axi_arvalid && s_q.arready) begin
			s_d.rvalid = 1'h1;
			s_d.rdata = '0;
			s_d.rresp = reg_known(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
			if (reg_hit(s_axi_araddr, OFF_CTRL)) begin
				s_d.rdata[CTRL_W-1:0] = s_q.ctrl;
				s_d.rdata[CTRL_CS] = !s_q.cs_n;
			end
			if (reg_hit(s_axi_araddr, OFF_CLKGEN)) s_d.rdata[DIV_W-1:0] = s_q.div;
			if (reg_hit(s_axi_araddr, OFF_TXDATA)) s_d.rdata[7:0] = s_q.tx;
			// Received byte is only stable between transfers
			if (reg_hit(s_axi_araddr, OFF_RXDATA) && !s_q.busy) begin
				s_d.rdata[7:0] = link.rx_byte;
				s_d.rx_full = 1'h0;
			end
			if (reg_hit(s_axi_araddr, OFF_STATUS)) begin
				s_d.rdata[ST_BUSY] = s_q.busy;
				s_d.rdata[ST_RXFULL] = s_q.rx_full;
			end
		end

		// Completion after the read clear, so a fresh byte is never lost
		if (done_ev) begin
			s_d.done_seen = done_s;
			s_d.busy = 1'h0;
			s_d.rx_full = 1'h1;
		end

		// Ready flags follow the holding state
		s_d.awready = !s_d.aw_have && !s_d.bvalid;
		s_d.wready = !s_d.w_have && !s_d.bvalid;
		s_d.arready = !s_d.rvalid;
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) s_q <= REG_RST;
		else s_q <= s_d;
	end

	// Bus answers straight from state
	assign s_axi_awready = s_q.awready;
	assign s_axi_wready = s_q.wready;
	assign s_axi_bvalid = s_q.bvalid;
	assign s_axi_bresp = s_q.bresp;
	assign s_axi_arready = s_q.arready;
	assign s_axi_rvalid = s_q.rvalid;
	assign s_axi_rdata = s_q.rdata;
	assign s_axi_rresp = s_q.rresp;
	assign chip_select_n = s_q.cs_n;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	property p_cs_follow;
		(wr_ctrl && s_q.w_strb[0]) |=> chip_select_n == !$past(s_q.w_data[CTRL_CS]);
	endproperty
	a_cs_follow: assert property (p_cs_follow) else $error("chip select missed write");

	property p_cfg_hold;
		s_q.busy |=> $stable(s_q.div) && $stable(s_q.ctrl) && $stable(s_q.tx);
	endproperty
	a_cfg_hold: assert property (p_cfg_hold) else $error("config moved during transfer");

	property p_start;
		(wr_tx && !s_q.busy && s_q.w_strb[0])
			|=> s_q.busy && $changed(s_q.start_tgl) ##1 $stable(s_q.start_tgl);
	endproperty
	a_start: assert property (p_start) else $error("byte write did not start");

	property p_bad_addr;
		(wr_fire && !reg_known(s_q.aw_addr)) |=> s_axi_bvalid
			&& s_axi_bresp == RESP_SLVERR;
	endproperty
	a_bad_addr: assert property (p_bad_addr) else $error("unmapped write not refused");

	property p_b_hold;
		(s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("write response dropped");

	property p_r_timing;
		(s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid && !s_axi_arready;
	endproperty
	a_r_timing: assert property (p_r_timing) else $error("read answer late");

	property p_done_sets;
		done_ev |=> !s_q.busy && s_q.rx_full;
	endproperty
	a_done_sets: assert property (p_done_sets) else $error("completion not recorded");

	// Refusals, write answer timing and held answers on the register bus
	property p_aw_refuse;
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
	endproperty
	a_aw_refuse: assert property (p_aw_refuse) else $error("write taken while answering");

	property p_w_refuse;
		s_q.w_have |-> !s_axi_wready;
	endproperty
	a_w_refuse: assert property (p_w_refuse) else $error("second data taken");

	property p_ar_refuse;
		s_axi_rvalid |-> !s_axi_arready;
	endproperty
	a_ar_refuse: assert property (p_ar_refuse) else $error("read taken while answering");

	property p_b_timing;
		wr_fire |=> s_axi_bvalid;
	endproperty
	a_b_timing: assert property (p_b_timing) else $error("write answer late");

	property p_r_hold;
		(s_axi_rvalid && !s_axi_rready) |=> s_axi_rvalid && $stable(s_axi_rdata)
			&& $stable(s_axi_rresp);
	endproperty
	a_r_hold: assert property (p_r_hold) else $error("read answer dropped");

	property p_bad_read;
		(s_axi_arvalid && s_axi_arready && !reg_known(s_axi_araddr))
			|=> s_axi_rresp == RESP_SLVERR;
	endproperty
	a_bad_read: assert property (p_bad_read) else $error("unmapped read not refused");

	// Transfer bookkeeping: busy, select and received byte
	property p_tx_busy;
		(wr_tx && s_q.busy) |=> $stable(s_q.start_tgl) && $stable(s_q.tx);
	endproperty
	a_tx_busy: assert property (p_tx_busy) else $error("byte taken while busy");

	property p_ctrl_busy;
		(wr_ctrl && s_q.busy) |=> $stable(s_q.ctrl);
	endproperty
	a_ctrl_busy: assert property (p_ctrl_busy) else $error("mode moved while busy");

	property p_sel_only;
		!(wr_ctrl && s_q.w_strb[0]) |=> $stable(chip_select_n);
	endproperty
	a_sel_only: assert property (p_sel_only) else $error("select moved without write");

	property p_busy_hold;
		(s_q.busy && !done_ev) |=> s_q.busy;
	endproperty
	a_busy_hold: assert property (p_busy_hold) else $error("busy dropped early");

	property p_rx_busy;
		(s_axi_arvalid && s_axi_arready && reg_hit(s_axi_araddr, OFF_RXDATA) && s_q.busy)
			|=> s_axi_rdata == 32'h0;
	endproperty
	a_rx_busy: assert property (p_rx_busy) else $error("byte shown while busy");

	property p_rx_clear;
		(s_axi_arvalid && s_axi_arready && reg_hit(s_axi_araddr, OFF_RXDATA)
			&& !s_q.busy && !done_ev) |=> !s_q.rx_full;
	endproperty
	a_rx_clear: assert property (p_rx_clear) else $error("read did not clear flag");

	property p_rx_keep;
		(s_q.rx_full && !(s_axi_arvalid && s_axi_arready)) |=> s_q.rx_full;
	endproperty
	a_rx_keep: assert property (p_rx_keep) else $error("flag lost without read");

	c_byte_done: cover property (s_q.busy ##[1:1000] !s_q.busy && s_q.rx_full);
	c_rx_read: cover property (s_axi_rvalid && s_axi_rready && s_q.rdata[7:0] != 8'h00);
endmodule // gsp_top
`default_nettype wire

/* verif/gsp_slave_model.sv */
// Serial slave model: launches and samples by the phase settings.
// Assumes an idle-low shift clock and an active-low select from the bench.
`timescale 1ns/1ps
`default_nettype none
module gsp_slave_model (
	input  wire logic       sck,
	input  wire logic       sel_n,
	input  wire logic       mosi,
	input  wire logic       tx_ph,
	input  wire logic       rx_ph,
	input  wire logic       lsb,
	input  wire logic [7:0] tx_byte,
	output logic            miso,
	output logic [7:0]      rx_byte
);
	int li, si, ne;
	function automatic int pos(input int k);
		return lsb ? k : 7 - k;
	endfunction
	initial miso = 1'b0;
	// Selection: early launch unless the slave waits for an edge
	always @(negedge sel_n) begin
		li = 0;
		si = 0;
		ne = 0;
		rx_byte = 8'h00;
		if (!rx_ph) begin
			miso = tx_byte[pos(0)];
			li = 1;
		end
	end
	// Released line flips so a stale bit never passes
	always @(posedge sel_n) miso = ~miso;
	// Sample before launch on every shift clock edge
	always @(sck) if (!sel_n && ne < 16) begin
		ne++;
		if ((ne % 2 == 1) != tx_ph && si < 8) begin
			rx_byte[pos(si)] = mosi;
			si++;
		end
		if ((ne % 2 == 1) == rx_ph && li < 8) begin
			miso = tx_byte[pos(li)];
			li++;
		end
	end
endmodule // gsp_slave_model
`default_nettype wire

/* verif/tb.sv */
// Bench: register traffic over AXI4-Lite, slave model, clock timing checks.
// Assumes the slave model is compiled first; expectations come from the rules.
`timescale 1ns/1ps
`default_nettype none
module tb;
	import gsp_pkg::*;
	logic             clk = 0, link_clk = 0, reset_n = 0;
	logic             awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [7:0]       awaddr = 0, araddr = 0, s_tx = 0;
	logic [31:0]      wdata = 0;
	logic [3:0]       wstrb = 0;
	logic [2:0]       mode_ctl = 0;
	logic             hd = 0, watch = 0;
	wire logic        awready, wready, bvalid, arready, rvalid, sck, cs_n, s_out;
	wire logic [1:0]  bresp, rresp, io_in;
	wire logic [31:0] rdata;
	wire logic [3:0]  io_out, io_oe_n;
	wire logic [7:0]  s_rx;
	int               failures = 0, comparisons = 0, half = 3, nr = 0;
	longint           tr = 0;
	logic [7:0]       exp_q[$];
	// Line zero resolved from enables, the slave drives it when released in half duplex; line one gets the inverse in half duplex
	assign io_in = {hd ? ~io_out[0] : s_out,
		io_oe_n[0] ? (hd ? s_out : ~io_out[0]) : io_out[0]};
	// Clocks unrelated in phase
	always #50 clk = ~clk;
	always #24 link_clk = ~link_clk;
	gsp_top #(.DIV_W(10)) dut (.clk(clk), .reset_n(reset_n), .link_clk(link_clk),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_bresp(bresp), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_araddr(araddr), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .serial_shift_clock(sck),
		.serial_io_out(io_out), .serial_io_oe_n(io_oe_n), .serial_io_in(io_in),
		.chip_select_n(cs_n));
	gsp_slave_model slv (.sck(sck), .sel_n(cs_n), .mosi(io_in[0]),
		.tx_ph(mode_ctl[CTRL_TXPH]), .rx_ph(mode_ctl[CTRL_RXPH]),
		.lsb(mode_ctl[CTRL_LSB]), .tx_byte(s_tx), .miso(s_out), .rx_byte(s_rx));
	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic complete_run;
		$display("Counts: %0d compared, %0d failed", comparisons, failures);
		if (failures == 0 && comparisons > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic timed_out(input string what);
		failures++;
		$display("[FAIL] %0t timeout %s", $time, what);
		complete_run();
	endtask
	// Shift clock period and high time inside a frame
	always @(posedge sck) if (watch) begin
		if (nr > 0) check(32'($time - tr), 32'(96 * half), "period");
		nr++;
		tr = $time;
	end
	always @(negedge sck) if (watch) check(32'($time - tr), 32'(48 * half), "high");
	task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hf;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge clk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		if (n == 50) timed_out("write");
		bready <= 1'b0;
		check({30'h0, bresp}, {30'h0, er}, "bresp");
		@(posedge clk); // Ready is never lowered and raised in one step
	endtask
	task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge clk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		if (n == 50) timed_out("read");
		rready <= 1'b0;
		d = rdata;
		r = rresp;
		@(posedge clk);
	endtask
	// One byte: configure, select, send, poll, read back, deselect
	task automatic xfer(input logic [2:0] m, input logic h, input logic hdtx,
		input logic [9:0] cg, input logic dbl);
		logic [31:0] d;
		logic [1:0]  r;
		logic [7:0]  t;
		int          n;
		t = 8'($urandom);
		s_tx <= 8'($urandom);
		mode_ctl <= m;
		hd <= h;
		half = (cg < 3) ? 3 : ((cg > 651) ? 651 : int'(cg));
		axw(OFF_CLKGEN, {22'h0, cg}, RESP_OKAY);
		axw(OFF_CTRL, {27'h1, hdtx, h, m}, RESP_OKAY);
		check({31'h0, cs_n}, 32'h0, "select");
		exp_q.push_back(s_tx);
		nr = 0;
		watch = 1;
		axw(OFF_TXDATA, {24'h0, t}, RESP_OKAY);
		// Mid-frame traffic must not disturb the byte in flight
		if (dbl) begin
			axw(OFF_TXDATA, {24'h0, ~t}, RESP_OKAY);
			axw(OFF_CTRL, 32'h20, RESP_OKAY);
			axr(OFF_RXDATA, d, r);
			check(d, 32'h0, "rx while busy");
		end
		for (n = 0; n < 4000; n++) begin
			axr(OFF_STATUS, d, r);
			if (!d[ST_BUSY]) break;
		end
		if (n == 4000) timed_out("busy");
		watch = 0;
		check(32'(nr), 32'd8, "pulses");
		check({31'h0, sck}, 32'h0, "idle");
		check({30'h0, d[1:0]}, 32'h2, "status");
		check({28'h0, io_oe_n}, {28'h0, 3'b111, h & !hdtx}, "enables");
		check({29'h0, io_out[3:1]}, 32'h0, "spare lines");
		axr(OFF_RXDATA, d, r);
		if (!h || hdtx) check({24'h0, s_rx}, {24'h0, t}, "slave rx");
		if (!h || !hdtx) check({24'h0, d[7:0]}, {24'h0, exp_q[0]}, "rx");
		void'(exp_q.pop_front());
		if (dbl) begin
			axr(OFF_CTRL, d, r);
			check(d, {27'h1, hdtx, h, m}, "ctrl kept");
		end
		axr(OFF_STATUS, d, r);
		check({31'h0, d[ST_RXFULL]}, 32'h0, "rx_full");
		axw(OFF_CTRL, 32'h0, RESP_OKAY);
		check({31'h0, cs_n}, 32'h1, "deselect");
		$display("test mode %0d hd %0d div %0d done", m, h, cg);
	endtask
	// Main sequence
	initial begin
		logic [31:0] d;
		logic [1:0]  r;
		void'($urandom(32'hc6ca));
		repeat (6) @(posedge clk);
		reset_n <= 1'b1;
		@(posedge clk);
		axr(OFF_CLKGEN, d, r);
		check({22'h0, d[9:0]}, 32'd3, "clkgen reset");
		axw(8'h14, 32'h0, RESP_SLVERR);
		axr(8'h14, d, r);
		check({30'h0, r}, {30'h0, RESP_SLVERR}, "rresp");
		$display("test unmapped done");
		for (int i = 0; i < 8; i++) xfer(3'(i), 0, 0, (i == 0) ? 10'h0 : 10'(3 + $urandom % 4), i == 5);
		xfer(3'h5, 0, 0, 10'h3ff, 0);
		xfer(3'($urandom), 1, 1, 10'h4, 0);
		xfer(3'($urandom), 1, 0, 10'h5, 0);
		complete_run();
	end
endmodule // tb
`default_nettype wire
